// ===== rtl/nfcd_bus_cycle.v
// One asynchronous write or read cycle on the flash pins
`include "nfcd_defs.vh"
module nfcd_bus_cycle (
  input  wire                clk,
  input  wire                rst,
  input  wire                start,
  input  wire                is_read,
  input  wire [`NFCD_AW-1:0] addr,
  input  wire [`NFCD_DW-1:0] wdata,
  input  wire [`NFCD_DW-1:0] dq_in,
  output reg                 ce_n,
  output reg                 we_n,
  output reg                 oe_n,
  output reg                 dq_oe_n,
  output reg  [`NFCD_AW-1:0] a_out,
  output reg  [`NFCD_DW-1:0] dq_out,
  output reg  [`NFCD_DW-1:0] rdata,
  output reg                 done
);
  localparam S_IDLE = 4'b0001;
  localparam S_SET  = 4'b0010;
  localparam S_ACT  = 4'b0100;
  localparam S_REC  = 4'b1000;
  localparam [7:0] SET_CYC = `NFCD_SET_CYC;
  localparam [7:0] WP_CYC  = `NFCD_WP_CYC;
  localparam [7:0] REC_CYC = `NFCD_REC_CYC;
  localparam [7:0] ACC_CYC = `NFCD_ACC_CYC;

  reg [3:0] state;
  reg [7:0] cnt;
  reg       rd;

  always @(posedge clk) begin
    if (rst) begin
      state   <= S_IDLE;
      cnt     <= 8'h00;
      rd      <= 1'b0;
      ce_n    <= 1'b1;
      we_n    <= 1'b1;
      oe_n    <= 1'b1;
      dq_oe_n <= 1'b1;
      a_out   <= {`NFCD_AW{1'b0}};
      dq_out  <= {`NFCD_DW{1'b0}};
      rdata   <= {`NFCD_DW{1'b0}};
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        S_IDLE: if (start) begin
          a_out   <= addr;
          dq_out  <= wdata;
          rd      <= is_read;
          ce_n    <= 1'b0;
          dq_oe_n <= is_read;
          cnt     <= 8'h01;
          state   <= S_SET;
        end
        S_SET: if (cnt >= SET_CYC) begin
          cnt   <= 8'h01;
          state <= S_ACT;
          if (rd) begin
            oe_n <= 1'b0;
          end else begin
            we_n <= 1'b0;
          end
        end else begin
          cnt <= cnt + 8'h01;
        end
        S_ACT: if (cnt >= (rd ? ACC_CYC : WP_CYC)) begin
          if (rd) begin
            rdata <= dq_in;
          end
          oe_n  <= 1'b1;
          we_n  <= 1'b1;
          cnt   <= 8'h01;
          state <= S_REC;
        end else begin
          cnt <= cnt + 8'h01;
        end
        S_REC: if (cnt >= REC_CYC) begin
          ce_n    <= 1'b1;
          dq_oe_n <= 1'b1;
          done    <= 1'b1;
          state   <= S_IDLE;
        end else begin
          cnt <= cnt + 8'h01;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== rtl/nfcd_defs.vh
// Constants of the flash command host
`ifndef NFCD_DEFS_VH
`define NFCD_DEFS_VH
`define NFCD_AW            27
`define NFCD_DW            16
// Bus cycle lengths in 25 ns clocks
`define NFCD_SET_CYC       8'h01
`define NFCD_WP_CYC        8'h02
`define NFCD_REC_CYC       8'h01
`define NFCD_ACC_CYC       8'h04
// Host operations on cmd_op
`define NFCD_OP_READ        5'h00
`define NFCD_OP_RESET1      5'h01
`define NFCD_OP_RESET3      5'h02
`define NFCD_OP_CFI         5'h03
`define NFCD_OP_AUTOSEL     5'h04
`define NFCD_OP_BYP_ENTER   5'h05
`define NFCD_OP_BYP_EXIT    5'h06
`define NFCD_OP_CHIP_ERASE  5'h07
`define NFCD_OP_BLOCK_ERASE 5'h08
`define NFCD_OP_ERASE_ADD   5'h09
`define NFCD_OP_SUSPEND     5'h0A
`define NFCD_OP_RESUME      5'h0B
`define NFCD_OP_BLANK_SETUP 5'h0C
`define NFCD_OP_BLANK_CONF  5'h0D
`define NFCD_OP_BUF_START   5'h0E
`define NFCD_OP_BUF_DATA    5'h0F
`define NFCD_OP_BUF_CONF    5'h10
`define NFCD_OP_LAST        5'h10
// Command codes
`define NFCD_D_UNLOCK1      8'hAA
`define NFCD_D_UNLOCK2      8'h55
`define NFCD_D_RESET        8'hF0
`define NFCD_D_CFI          8'h98
`define NFCD_D_AUTOSEL      8'h90
`define NFCD_D_BYPASS       8'h20
`define NFCD_D_BYP_EXIT2    8'h00
`define NFCD_D_ERASE        8'h80
`define NFCD_D_CHIP         8'h10
`define NFCD_D_BLOCK        8'h30
`define NFCD_D_SUSPEND      8'hB0
`define NFCD_D_RESUME       8'h30
`define NFCD_D_BLANK1       8'hEB
`define NFCD_D_BLANK2       8'h76
`define NFCD_D_BLANK3       8'h00
`define NFCD_D_CONFIRM      8'h29
`define NFCD_D_BUFLOAD      8'h25
// Unlock addresses
`define NFCD_U1_X8          27'h0000AAA
`define NFCD_U1_X16         27'h0000555
`define NFCD_U2_X8          27'h0000555
`define NFCD_U2_X16         27'h00002AA
// Buffer program limits
`define NFCD_BUF_MAXN_X8    16'h00FF
`define NFCD_BUF_MAXN_X16   16'h01FF
`define NFCD_BUF_CYC_X8     10'h105
`define NFCD_BUF_CYC_X16    10'h205
`define NFCD_BUF_CYC_BX8    10'h103
`define NFCD_BUF_CYC_BX16   10'h203
`define NFCD_ABORT_BIT      1
`endif

// ===== rtl/nfcd_host.v
// Host issuing flash command sequences, tracking flash modes
// Notes on behaviour
// - Chip erase AA,55,80,AA,55,10.
// - Block erase ends 30 at a block; more 30s add blocks.
// - Bypass erase is 80,10 or 80,30.
// - B0 suspends, 30 resumes.
// - Count is items less one; 256 bytes or 512 words most.
// - At most 261/517 cycles, bypass 259/515.
// - Confirm 29 to the loaded block.
// - Loading varies only low address bits.
// - Abort error needs three-write reset.
// - Only 90,00 leaves bypass.
// - Auto select AA,55,90; left by reset or CFI.
`include "nfcd_defs.vh"
module nfcd_host (
  input  wire                clk,
  input  wire                rst,
  input  wire                byte_mode,
  input  wire                cmd_valid,
  input  wire [4:0]          cmd_op,
  input  wire [`NFCD_AW-1:0] cmd_addr,
  input  wire [`NFCD_DW-1:0] cmd_data,
  input  wire                flash_rdy,
  input  wire [`NFCD_DW-1:0] flash_dq_in,
  output reg                 cmd_ready,
  output reg                 cmd_done,
  output reg                 cmd_refused,
  output reg                 rsp_valid,
  output reg  [`NFCD_DW-1:0] rsp_data,
  output reg                 stat_bypass,
  output reg                 stat_suspended,
  output reg                 stat_cfi,
  output reg                 stat_autosel,
  output reg                 stat_busy,
  output reg                 stat_abort,
  output reg                 flash_byte_n,
  output wire                flash_ce_n,
  output wire                flash_we_n,
  output wire                flash_oe_n,
  output wire [`NFCD_AW-1:0] flash_addr,
  output wire [`NFCD_DW-1:0] flash_dq_out,
  output wire                flash_dq_oe_n
);
  localparam S_IDLE  = 3'b001;
  localparam S_ISSUE = 3'b010;
  localparam S_WAIT  = 3'b100;
  localparam [1:0] A_X  = 2'd0;
  localparam [1:0] A_U1 = 2'd1;
  localparam [1:0] A_U2 = 2'd2;
  localparam [1:0] A_UA = 2'd3;

  // Cycle word: {last, address select, data select, byte}
  function [11:0] cyc;
    input       last;
    input [1:0] asel;
    input       dsel;
    input [7:0] d;
    begin
      cyc = {last, asel, dsel, d};
    end
  endfunction

  function [11:0] seq;
    input [4:0] op;
    input [3:0] step;
    input       byp;
    reg   [3:0] s;
    begin
      s   = byp ? step + 4'd2 : step;
      seq = cyc(1'b1, A_X, 1'b0, `NFCD_D_RESET);
      case (op)
        `NFCD_OP_READ:      seq = cyc(1'b1, A_UA, 1'b0, 8'h00);
        `NFCD_OP_RESET1:    seq = cyc(1'b1, A_X, 1'b0, `NFCD_D_RESET);
        `NFCD_OP_RESET3, `NFCD_OP_AUTOSEL, `NFCD_OP_BYP_ENTER: begin
          if (step == 4'd0) begin
            seq = cyc(1'b0, A_U1, 1'b0, `NFCD_D_UNLOCK1);
          end else if (step == 4'd1) begin
            seq = cyc(1'b0, A_U2, 1'b0, `NFCD_D_UNLOCK2);
          end else if (op == `NFCD_OP_RESET3) begin
            seq = cyc(1'b1, A_X, 1'b0, `NFCD_D_RESET);
          end else if (op == `NFCD_OP_AUTOSEL) begin
            seq = cyc(1'b1, A_U1, 1'b0, `NFCD_D_AUTOSEL);
          end else begin
            seq = cyc(1'b1, A_U1, 1'b0, `NFCD_D_BYPASS);
          end
        end
        `NFCD_OP_CFI:       seq = cyc(1'b1, A_U1, 1'b0, `NFCD_D_CFI);
        `NFCD_OP_BYP_EXIT:
          seq = (step == 4'd0) ? cyc(1'b0, A_X, 1'b0, `NFCD_D_AUTOSEL)
                : cyc(1'b1, A_X, 1'b0, `NFCD_D_BYP_EXIT2);
        `NFCD_OP_CHIP_ERASE, `NFCD_OP_BLOCK_ERASE: begin
          if (byp) begin
            if (step == 4'd0) begin
              seq = cyc(1'b0, A_X, 1'b0, `NFCD_D_ERASE);
            end else if (op == `NFCD_OP_BLOCK_ERASE) begin
              seq = cyc(1'b1, A_UA, 1'b0, `NFCD_D_BLOCK);
            end else begin
              seq = cyc(1'b1, A_X, 1'b0, `NFCD_D_CHIP);
            end
          end else if (step == 4'd0 || step == 4'd3) begin
            seq = cyc(1'b0, A_U1, 1'b0, `NFCD_D_UNLOCK1);
          end else if (step == 4'd1 || step == 4'd4) begin
            seq = cyc(1'b0, A_U2, 1'b0, `NFCD_D_UNLOCK2);
          end else if (step == 4'd2) begin
            seq = cyc(1'b0, A_U1, 1'b0, `NFCD_D_ERASE);
          end else if (op == `NFCD_OP_BLOCK_ERASE) begin
            seq = cyc(1'b1, A_UA, 1'b0, `NFCD_D_BLOCK);
          end else begin
            seq = cyc(1'b1, A_U1, 1'b0, `NFCD_D_CHIP);
          end
        end
        `NFCD_OP_ERASE_ADD: seq = cyc(1'b1, A_UA, 1'b0, `NFCD_D_BLOCK);
        `NFCD_OP_SUSPEND:   seq = cyc(1'b1, A_X, 1'b0, `NFCD_D_SUSPEND);
        `NFCD_OP_RESUME:    seq = cyc(1'b1, A_X, 1'b0, `NFCD_D_RESUME);
        `NFCD_OP_BLANK_SETUP: begin
          case (step)
            4'd0:    seq = cyc(1'b0, A_U1, 1'b0, `NFCD_D_UNLOCK1);
            4'd1:    seq = cyc(1'b0, A_U2, 1'b0, `NFCD_D_UNLOCK2);
            4'd2:    seq = cyc(1'b0, A_UA, 1'b0, `NFCD_D_BLANK1);
            4'd3:    seq = cyc(1'b0, A_UA, 1'b0, `NFCD_D_BLANK2);
            4'd4:    seq = cyc(1'b0, A_UA, 1'b0, `NFCD_D_BLANK3);
            default: seq = cyc(1'b1, A_UA, 1'b0, `NFCD_D_BLANK3);
          endcase
        end
        `NFCD_OP_BLANK_CONF, `NFCD_OP_BUF_CONF:
          seq = cyc(1'b1, A_UA, 1'b0, `NFCD_D_CONFIRM);
        `NFCD_OP_BUF_START: begin
          case (s)
            4'd0:    seq = cyc(1'b0, A_U1, 1'b0, `NFCD_D_UNLOCK1);
            4'd1:    seq = cyc(1'b0, A_U2, 1'b0, `NFCD_D_UNLOCK2);
            4'd2:    seq = cyc(1'b0, A_UA, 1'b0, `NFCD_D_BUFLOAD);
            default: seq = cyc(1'b1, A_UA, 1'b1, 8'h00);
          endcase
        end
        `NFCD_OP_BUF_DATA:  seq = cyc(1'b1, A_UA, 1'b1, 8'h00);
        default:            seq = cyc(1'b1, A_X, 1'b0, `NFCD_D_RESET);
      endcase
    end
  endfunction

  reg  [2:0]          state;
  reg  [4:0]          op_q;
  reg  [3:0]          step;
  reg  [`NFCD_AW-1:0] addr_q;
  reg  [`NFCD_DW-1:0] data_q;
  reg                 eng_start;
  reg                 erase_open;
  reg                 blank_open;
  reg                 buf_open;
  reg  [9:0]          buf_left;
  reg  [9:0]          buf_cyc;
  reg  [`NFCD_AW-1:0] blk_base;
  reg                 rdy_q;
  reg                 legal;
  reg  [`NFCD_AW-1:0] cyc_addr;
  wire [11:0]         cur = seq(op_q, step, stat_bypass);
  wire [`NFCD_DW-1:0] eng_rdata;
  wire                eng_done;
  wire [15:0]         max_n = byte_mode ? `NFCD_BUF_MAXN_X8
                                        : `NFCD_BUF_MAXN_X16;
  wire [9:0]          cyc_lim = stat_bypass
      ? (byte_mode ? `NFCD_BUF_CYC_BX8 : `NFCD_BUF_CYC_BX16)
      : (byte_mode ? `NFCD_BUF_CYC_X8 : `NFCD_BUF_CYC_X16);
  wire                same_page = byte_mode
      ? (cmd_addr[`NFCD_AW-1:8] == blk_base[`NFCD_AW-1:8])
      : (cmd_addr[`NFCD_AW-1:9] == blk_base[`NFCD_AW-1:9]);
  wire [`NFCD_DW-1:0] cyc_data = cur[8] ? data_q : {8'h00, cur[7:0]};

  always @* begin
    case (cur[10:9])
      A_U1:    cyc_addr = byte_mode ? `NFCD_U1_X8 : `NFCD_U1_X16;
      A_U2:    cyc_addr = byte_mode ? `NFCD_U2_X8 : `NFCD_U2_X16;
      A_UA:    cyc_addr = addr_q;
      default: cyc_addr = {`NFCD_AW{1'b0}};
    endcase
  end

  // Acceptance of the offered operation
  always @* begin
    legal = 1'b1;
    if (cmd_op > `NFCD_OP_LAST) begin
      legal = 1'b0;
    end else if (stat_busy && !(cmd_op == `NFCD_OP_READ
        || cmd_op == `NFCD_OP_SUSPEND
        || (cmd_op == `NFCD_OP_ERASE_ADD && erase_open))) begin
      legal = 1'b0;
    end else if (buf_open && !(cmd_op == `NFCD_OP_READ
        || cmd_op == `NFCD_OP_BUF_DATA || cmd_op == `NFCD_OP_BUF_CONF
        || cmd_op == `NFCD_OP_RESET3)) begin
      legal = 1'b0;
    end else if (cmd_op == `NFCD_OP_RESET1 && stat_abort) begin
      legal = 1'b0;
    end else if (cmd_op == `NFCD_OP_CFI && stat_cfi) begin
      legal = 1'b0;
    end else if ((cmd_op == `NFCD_OP_SUSPEND && !stat_busy)
        || (cmd_op == `NFCD_OP_RESUME && !stat_suspended)
        || (cmd_op == `NFCD_OP_ERASE_ADD && !erase_open)
        || (cmd_op == `NFCD_OP_BLANK_CONF && !blank_open)
        || (cmd_op == `NFCD_OP_BYP_ENTER && stat_bypass)
        || (cmd_op == `NFCD_OP_BYP_EXIT && !stat_bypass)) begin
      legal = 1'b0;
    end else if (cmd_op == `NFCD_OP_BUF_START && cmd_data > max_n) begin
      legal = 1'b0;
    end else if (cmd_op == `NFCD_OP_BUF_DATA && (!buf_open
        || buf_left == 10'd0 || !same_page
        || buf_cyc + 10'd2 > cyc_lim)) begin
      legal = 1'b0;
    end else if (cmd_op == `NFCD_OP_BUF_CONF
        && (!buf_open || buf_left != 10'd0)) begin
      legal = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state          <= S_IDLE;
      op_q           <= `NFCD_OP_READ;
      step           <= 4'd0;
      addr_q         <= {`NFCD_AW{1'b0}};
      data_q         <= {`NFCD_DW{1'b0}};
      eng_start      <= 1'b0;
      erase_open     <= 1'b0;
      blank_open     <= 1'b0;
      buf_open       <= 1'b0;
      buf_left       <= 10'd0;
      buf_cyc        <= 10'd0;
      blk_base       <= {`NFCD_AW{1'b0}};
      rdy_q          <= 1'b1;
      cmd_ready      <= 1'b0;
      cmd_done       <= 1'b0;
      cmd_refused    <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_data       <= {`NFCD_DW{1'b0}};
      stat_bypass    <= 1'b0;
      stat_suspended <= 1'b0;
      stat_cfi       <= 1'b0;
      stat_autosel   <= 1'b0;
      stat_busy      <= 1'b0;
      stat_abort     <= 1'b0;
      flash_byte_n   <= 1'b1;
    end else begin
      cmd_done     <= 1'b0;
      cmd_refused  <= 1'b0;
      rsp_valid    <= 1'b0;
      eng_start    <= 1'b0;
      rdy_q        <= flash_rdy;
      flash_byte_n <= ~byte_mode;
      if (flash_rdy && !rdy_q) begin
        stat_busy <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            if (legal) begin
              op_q   <= cmd_op;
              step   <= 4'd0;
              addr_q <= (cmd_op == `NFCD_OP_BUF_CONF
                  || cmd_op == `NFCD_OP_BLANK_CONF) ? blk_base
                  : cmd_addr;
              data_q <= cmd_data;
              state  <= S_ISSUE;
            end else begin
              cmd_refused <= 1'b1;
            end
          end
        end
        S_ISSUE: begin
          eng_start <= 1'b1;
          state     <= S_WAIT;
        end
        S_WAIT: if (eng_done) begin
          if (op_q == `NFCD_OP_READ) begin
            rsp_valid <= 1'b1;
            rsp_data  <= eng_rdata;
            if (stat_busy && eng_rdata[`NFCD_ABORT_BIT]) begin
              stat_abort <= 1'b1;
            end
          end
          if (!cur[11]) begin
            step  <= step + 4'd1;
            state <= S_ISSUE;
          end else begin
            cmd_done  <= 1'b1;
            cmd_ready <= 1'b1;
            state     <= S_IDLE;
            if (op_q != `NFCD_OP_READ) begin
              erase_open <= 1'b0;
              if (op_q != `NFCD_OP_BLANK_SETUP) begin
                blank_open <= 1'b0;
              end
            end
            case (op_q)
              `NFCD_OP_RESET1, `NFCD_OP_RESET3: begin
                stat_cfi     <= 1'b0;
                stat_autosel <= 1'b0;
                stat_abort   <= 1'b0;
                buf_open     <= 1'b0;
              end
              `NFCD_OP_CFI: begin
                stat_cfi     <= 1'b1;
                stat_autosel <= 1'b0;
              end
              `NFCD_OP_AUTOSEL:   stat_autosel <= 1'b1;
              `NFCD_OP_BYP_ENTER: stat_bypass <= 1'b1;
              `NFCD_OP_BYP_EXIT:  stat_bypass <= 1'b0;
              `NFCD_OP_CHIP_ERASE: stat_busy <= 1'b1;
              `NFCD_OP_BLOCK_ERASE, `NFCD_OP_ERASE_ADD: begin
                stat_busy  <= 1'b1;
                erase_open <= 1'b1;
              end
              `NFCD_OP_SUSPEND: begin
                stat_busy      <= 1'b0;
                stat_suspended <= 1'b1;
              end
              `NFCD_OP_RESUME: begin
                stat_busy      <= 1'b1;
                stat_suspended <= 1'b0;
              end
              `NFCD_OP_BLANK_SETUP: begin
                blank_open <= 1'b1;
                blk_base   <= addr_q;
              end
              `NFCD_OP_BLANK_CONF: stat_busy <= 1'b1;
              `NFCD_OP_BUF_START: begin
                buf_open <= 1'b1;
                blk_base <= addr_q;
                buf_left <= data_q[9:0] + 10'd1;
                buf_cyc  <= stat_bypass ? 10'd2 : 10'd4;
              end
              `NFCD_OP_BUF_DATA: begin
                buf_left <= buf_left - 10'd1;
                buf_cyc  <= buf_cyc + 10'd1;
              end
              `NFCD_OP_BUF_CONF: begin
                buf_open  <= 1'b0;
                stat_busy <= 1'b1;
              end
              default: ;
            endcase
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  nfcd_bus_cycle u_cycle (
    .clk     (clk),
    .rst     (rst),
    .start   (eng_start),
    .is_read (op_q == `NFCD_OP_READ),
    .addr    (cyc_addr),
    .wdata   (cyc_data),
    .dq_in   (flash_dq_in),
    .ce_n    (flash_ce_n),
    .we_n    (flash_we_n),
    .oe_n    (flash_oe_n),
    .dq_oe_n (flash_dq_oe_n),
    .a_out   (flash_addr),
    .dq_out  (flash_dq_out),
    .rdata   (eng_rdata),
    .done    (eng_done)
  );
endmodule

// ===== testbench/nfcd_flash_model.sv
// Flash model decoding the host's cycles
`include "nfcd_defs.vh"
module nfcd_flash_model (
  input  wire        clk,
  input  wire        byte_n,
  input  wire        ce_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire [26:0] a,
  input  wire [15:0] d,
  input  wire        abort_inj,
  output wire        rdy,
  output reg  [15:0] q,
  output wire [4:0]  mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // Arbitrary identification value
  localparam [15:0] ID_CODE = 16'h00C3;
  localparam [5:0]  BUSY    = 6'h3C;
  reg        we_q   = 1'b1;
  reg [4:0]  st     = 5'h00;
  reg [5:0]  bcnt   = 6'h00;
  reg [26:0] ba     = 27'h0000000;
  reg [9:0]  left   = 10'h000;
  reg        byp    = 1'b0;
  reg        sus    = 1'b0;
  reg        cfi    = 1'b0;
  reg        asel   = 1'b0;
  reg        err    = 1'b0;
  integer    blocks = 0;
  wire [7:0] c      = d[7:0];
  wire       x8     = !byte_n;
  wire       u1     = a == (x8 ? `NFCD_U1_X8 : `NFCD_U1_X16);
  wire       u2     = a == (x8 ? `NFCD_U2_X8 : `NFCD_U2_X16);
  wire       wr     = we_n && !we_q && !ce_n;
  wire       busy   = bcnt != 6'h00;
  assign rdy  = !busy;
  assign mode = {byp, sus, cfi, asel, busy};
  initial q = 16'h0000;
  always @(posedge clk) begin
    we_q <= we_n;
    if (busy)
      bcnt <= bcnt - 6'h01;
    // Idle bus toggles
    if (!ce_n && !oe_n)
      q <= asel ? (a[1:0] == 2'h0 ? ID_CODE : 16'h0000) :
           cfi ? 16'h0051 : busy ? {14'h0000, err, 1'b0} :
           a[15:0] ^ 16'hA5A5;
    else
      q <= ~q;
    if (wr) begin
      st <= 5'h00;
      if (st == 5'h0B) begin
        left <= d[9:0] + 10'h001;
        err <= d > (x8 ? `NFCD_BUF_MAXN_X8 : `NFCD_BUF_MAXN_X16);
        st <= 5'h0C;
      end else if (st == 5'h0C && left != 10'h000) begin
        left <= left - 10'h001;
        st <= 5'h0C;
        if (x8 ? a[26:8] != ba[26:8] : a[26:9] != ba[26:9])
          err <= 1'b1;
      end else if (st == 5'h0C && c == 8'h29) begin
        bcnt <= BUSY;
        err <= abort_inj || a != ba;
      end else
        case (c)
          8'hAA: if (u1) st <= (st == 5'h03) ? 5'h04 : 5'h01;
          8'h55: if (u2 && (st == 5'h01 || st == 5'h04)) st <= st + 5'h01;
          8'h80: if (st == 5'h02 || (byp && st == 5'h00)) st <= 5'h03;
          8'h10: if (st == 5'h05 || (byp && st == 5'h03)) bcnt <= BUSY;
          8'h30:
            if (st == 5'h05 || (byp && st == 5'h03) || busy) begin
              bcnt <= BUSY;
              blocks <= blocks + 1;
            end else if (sus && st == 5'h00) begin
              sus <= 1'b0;
              bcnt <= BUSY;
            end
          8'hB0:
            if (busy) begin
              sus <= 1'b1;
              bcnt <= 6'h00;
            end
          8'hF0:
            if (!busy && (!err || st == 5'h02)) begin
              cfi <= 1'b0;
              asel <= 1'b0;
              err <= 1'b0;
            end
          8'h98:
            if (u1 && !busy && !cfi) begin
              cfi <= 1'b1;
              asel <= 1'b0;
            end
          8'h90:
            if (byp && st == 5'h00) st <= 5'h06;
            else if (st == 5'h02 && u1 && !busy) asel <= 1'b1;
          8'h00:
            if (st == 5'h06) byp <= 1'b0;
            else if (st == 5'h08 || st == 5'h09) st <= st + 5'h01;
          8'h20: if (st == 5'h02 && u1) byp <= 1'b1;
          8'hEB: if (st == 5'h02) st <= 5'h07;
          8'h76: if (st == 5'h07) st <= 5'h08;
          8'h29: if (st == 5'h0A) bcnt <= BUSY;
          8'h25:
            if (st == 5'h02 || (byp && st == 5'h00)) begin
              st <= 5'h0B;
              ba <= a;
            end
          default: ;
        endcase
    end
  end
endmodule

// ===== testbench/nfcd_host_properties.sv
// Checks on the host's ports
`include "nfcd_defs.vh"
module nfcd_host_properties (
  input wire        clk,
  input wire        rst,
  input wire        byte_mode,
  input wire        cmd_valid,
  input wire [4:0]  cmd_op,
  input wire [15:0] cmd_data,
  input wire        cmd_ready,
  input wire        cmd_refused,
  input wire        stat_bypass,
  input wire        stat_cfi,
  input wire        stat_busy,
  input wire        stat_abort,
  input wire        flash_ce_n,
  input wire        flash_we_n,
  input wire        flash_dq_oe_n,
  input wire [26:0] flash_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire take = cmd_valid && cmd_ready;
  chk_reset_idle:
    assert property ($fell(rst) |-> flash_ce_n && flash_we_n && !cmd_ready)
    else $error("Active after reset");
  chk_write_frame:
    assert property (!flash_we_n |-> !flash_ce_n && !flash_dq_oe_n)
    else $error("Write outside cycle");
  chk_addr_hold:
    assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
    else $error("Address moved");
  chk_busy_reset:
    assert property (take && stat_busy && cmd_op == `NFCD_OP_RESET1
                     |=> cmd_refused)
    else $error("Busy reset taken");
  chk_abort_reset:
    assert property (take && stat_abort && cmd_op == `NFCD_OP_RESET1
                     |=> cmd_refused)
    else $error("Abort reset taken");
  chk_bypass_kept:
    assert property (take && stat_bypass && (cmd_op == `NFCD_OP_RESET1 ||
                     cmd_op == `NFCD_OP_RESET3) |=> stat_bypass [*8])
    else $error("Bypass lost on reset");
  chk_cfi_again:
    assert property (take && stat_cfi && cmd_op == `NFCD_OP_CFI |=> cmd_refused)
    else $error("CFI reentry taken");
  chk_buf_limit:
    assert property (take && cmd_op == `NFCD_OP_BUF_START && cmd_data >
      (byte_mode ? `NFCD_BUF_MAXN_X8 : `NFCD_BUF_MAXN_X16) |=> cmd_refused)
    else $error("Big count taken");
endmodule
bind nfcd_host nfcd_host_properties u_nfcd_host_properties (.*);

// ===== testbench/testbench.sv
// Bench for the flash command host
`include "nfcd_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [26:0] BA = 27'h0020000;
  localparam [26:0] Z  = 27'h0000010;
  localparam [15:0] D0 = 16'h0000;
  reg                 clk       = 1'b0;
  reg                 rst       = 1'b1;
  reg                 byte_mode = 1'b1;
  reg                 cmd_valid = 1'b0;
  reg                 abort_inj = 1'b0;
  reg  [4:0]          cmd_op    = 5'h00;
  reg  [`NFCD_AW-1:0] cmd_addr  = 27'h0000000;
  reg  [15:0]         cmd_data  = 16'h0000;
  wire                flash_rdy, cmd_ready, cmd_done, cmd_refused, rsp_valid;
  wire [15:0]         flash_dq_in, rsp_data, flash_dq_out;
  wire                stat_bypass, stat_suspended, stat_cfi, stat_autosel;
  wire                stat_busy, stat_abort, flash_byte_n, flash_ce_n;
  wire                flash_we_n, flash_oe_n, flash_dq_oe_n;
  wire [26:0]         flash_addr;
  wire [4:0]          fmode;
  wire [4:0]          hmode = {stat_bypass, stat_suspended, stat_cfi,
                               stat_autosel, stat_busy};
  integer             mismatches = 0;
  integer             checked    = 0;
  integer             i;
  reg  [10:0]         rows [0:15];
  always #12.5 clk = ~clk;
  nfcd_host u_nfcd_host (.*);
  nfcd_flash_model u_nfcd_flash_model (.clk(clk), .byte_n(flash_byte_n),
    .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n), .a(flash_addr),
    .d(flash_dq_out), .abort_inj(abort_inj), .rdy(flash_rdy),
    .q(flash_dq_in), .mode(fmode));
  task test_done;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task lapse(input integer n);
    if (n >= 400) begin
      mismatches = mismatches + 1;
      $display("ERROR %0t wait ran out", $time);
      test_done;
    end
  endtask
  // Offer one operation, check refusal, response and modes
  task op(input [4:0] o, input [26:0] ad, input [15:0] dt, input rf,
          input [4:0] m);
    integer   n;
    reg [1:0] r;
    begin
      @(posedge clk);
      cmd_op <= o;
      cmd_addr <= ad;
      cmd_data <= dt;
      cmd_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (cmd_ready !== 1'b1 && n < 400);
      cmd_valid <= 1'b0;
      lapse(n);
      for (n = 0; cmd_done !== 1'b1 && cmd_refused !== 1'b1 && n < 400;
           n = n + 1)
        @(posedge clk);
      lapse(n);
      r = {rsp_valid, cmd_refused};
      #1;
      cmp(r, {o == `NFCD_OP_READ && !rf, rf});
      cmp(hmode, m);
      cmp(fmode, m);
    end
  endtask
  task idle;
    integer n;
    begin
      for (n = 0; stat_busy !== 1'b0 && n < 400; n = n + 1)
        @(posedge clk);
      lapse(n);
    end
  endtask
  initial begin
    rows = '{{`NFCD_OP_READ, 6'h00}, {`NFCD_OP_CFI, 6'h04},
      {`NFCD_OP_CFI, 6'h24}, {`NFCD_OP_RESET1, 6'h00},
      {`NFCD_OP_AUTOSEL, 6'h02}, {`NFCD_OP_CFI, 6'h04},
      {`NFCD_OP_RESET3, 6'h00}, {`NFCD_OP_BYP_ENTER, 6'h10},
      {`NFCD_OP_RESET1, 6'h10}, {`NFCD_OP_BYP_ENTER, 6'h30},
      {`NFCD_OP_CHIP_ERASE, 6'h11}, {`NFCD_OP_RESET1, 6'h31},
      {`NFCD_OP_SUSPEND, 6'h18}, {`NFCD_OP_AUTOSEL, 6'h1A},
      {`NFCD_OP_RESET1, 6'h18}, {`NFCD_OP_RESUME, 6'h11}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
      op(rows[i][10:6], Z, D0, rows[i][5], rows[i][4:0]);
    cmp(rsp_data, 16'hA5B5);
    $display("table done");
    idle;
    op(`NFCD_OP_BYP_EXIT, Z, D0, 1'b0, 5'h00);
    op(`NFCD_OP_BLOCK_ERASE, BA, D0, 1'b0, 5'h01);
    op(`NFCD_OP_ERASE_ADD, 27'h0040000, D0, 1'b0, 5'h01);
    cmp(u_nfcd_flash_model.blocks[15:0], 16'h0002);
    idle;
    op(`NFCD_OP_AUTOSEL, Z, D0, 1'b0, 5'h02);
    op(`NFCD_OP_READ, 27'h0000000, D0, 1'b0, 5'h02);
    cmp(rsp_data, 16'h00C3);
    op(`NFCD_OP_RESET1, Z, D0, 1'b0, 5'h00);
    op(`NFCD_OP_BLANK_SETUP, BA, D0, 1'b0, 5'h00);
    op(`NFCD_OP_BLANK_CONF, BA, D0, 1'b0, 5'h01);
    idle;
    $display("erase done");
    op(`NFCD_OP_BUF_START, BA, 16'h0100, 1'b1, 5'h00);
    op(`NFCD_OP_BUF_START, BA, 16'h00FF, 1'b0, 5'h00);
    for (i = 0; i < 257; i = i + 1)
      op(`NFCD_OP_BUF_DATA, BA + i[26:0], i[15:0], i == 256, 5'h00);
    op(`NFCD_OP_BUF_CONF, BA, D0, 1'b0, 5'h01);
    cmp(u_nfcd_flash_model.err, 1'b0);
    idle;
    abort_inj <= 1'b1;
    op(`NFCD_OP_BUF_START, BA, D0, 1'b0, 5'h00);
    op(`NFCD_OP_BUF_DATA, BA, 16'h1234, 1'b0, 5'h00);
    op(`NFCD_OP_BUF_CONF, BA, D0, 1'b0, 5'h01);
    op(`NFCD_OP_READ, Z, D0, 1'b0, 5'h01);
    cmp(stat_abort, 1'b1);
    idle;
    op(`NFCD_OP_RESET1, Z, D0, 1'b1, 5'h00);
    op(`NFCD_OP_RESET3, Z, D0, 1'b0, 5'h00);
    cmp(stat_abort, 1'b0);
    $display("buffer done");
    @(posedge clk);
    rst <= 1'b1;
    byte_mode <= 1'b0;
    abort_inj <= 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    op(`NFCD_OP_CFI, Z, D0, 1'b0, 5'h04);
    op(`NFCD_OP_RESET1, Z, D0, 1'b0, 5'h00);
    $display("word mode done");
    test_done;
  end
endmodule
